// ===== shared/uatx_pkg.sv
// Shared constants and types of the asynchronous serial transmitter
package uatx_pkg;

  // Register bus geometry
  localparam int UATX_AW = 3;
  localparam int UATX_DW = 8;

  // Register offsets
  localparam logic [2:0] UATX_OFS_TXCTL = 3'h0;
  localparam logic [2:0] UATX_OFS_PORT = 3'h1;
  localparam logic [2:0] UATX_OFS_BAUD = 3'h2;
  localparam logic [2:0] UATX_OFS_BRGL = 3'h3;
  localparam logic [2:0] UATX_OFS_BRGH = 3'h4;
  localparam logic [2:0] UATX_OFS_HOLD = 3'h5;
  localparam logic [2:0] UATX_OFS_FLAG = 3'h6;
  localparam logic [2:0] UATX_OFS_IEN = 3'h7;

  // Field positions in transmit_status_control
  localparam int UATX_TXC_NINTH = 0;
  localparam int UATX_TXC_EMPTY = 1;
  localparam int UATX_TXC_NINE = 2;
  localparam int UATX_TXC_SYNC = 4;
  localparam int UATX_TXC_TRANSMIT_ENABLE = 5;
  // Field position in receive_status_control
  localparam int UATX_PORT_SERIAL_PORT_ENABLE = 7;
  // Field positions in baud_control
  localparam int UATX_BAUD_BRG16 = 3;
  localparam int UATX_BAUD_POL = 4;
  // Field position in the flag and enable registers
  localparam int UATX_FLAG_TXBE = 0;

  // Reset values
  localparam logic [15:0] UATX_BRG_RST = 16'h0000;
  localparam logic [8:0] UATX_WORD_RST = 9'h000;
  localparam logic [7:0] UATX_BYTE_RST = 8'h00;

  // Character lengths, counted from zero
  localparam logic [3:0] UATX_LAST8 = 4'h7;
  localparam logic [3:0] UATX_LAST9 = 4'h8;

  typedef enum logic [1:0] {
    UATX_IDLE,
    UATX_START,
    UATX_DATA,
    UATX_STOP
  } uatx_phase_t;

  // Character format and baud setting shared with the receiver
  typedef struct packed {
    logic nine;
    logic brg16;
    logic [15:0] brg;
  } uatx_cfg_t;

  // Complete state of the transmitter
  typedef struct packed {
    uatx_phase_t st;
    logic transmit_enable;
    logic sync;
    logic serial_port_enable;
    logic pol;
    logic ninth;
    uatx_cfg_t cfg;
    logic [8:0] hold;
    logic full;
    logic [8:0] shift;
    logic [3:0] bits;
    logic [3:0] last;
    logic [15:0] cnt;
    logic line;
    logic pin;
    logic oe;
    logic flag;
    logic irq_en;
    logic irq;
    logic [7:0] rdata;
  } uatx_state_t;

endpackage

// ===== design/uatx_top.sv
// Asynchronous serial transmitter with holding buffer and register port
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Frame: space start, data, mark stop
// - Idle line rests at mark, NRZ
// - Data bits go out LSB first
// - Each bit lasts one baud period
// - No hardware parity; software uses ninth
// - Active only when enabled, async, port on
// - Port enable turns pin driver on
// - Transmit enable raises buffer-empty flag when async with port on
// - Write loads idle shift register at once
// - Queued character loads right after stop
// - Frame starts right after the load
// - Polarity select inverts idle and data
// - Flag clear only when busy and queued, or inactive
// - Flag correct by first cycle after write
// - Flag is read-only to software
// - Interrupt enable gates request, not flag
// - Shift-empty status clears while shifting
// - Nine-bit mode sends ninth bit last
// - Ninth bit written first, loaded together
// - Serial output also feeds logic cell
// - Receiver shares format and baud setting
module uatx_top
  import uatx_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [UATX_AW-1:0] reg_addr,
  input wire logic [UATX_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [UATX_DW-1:0] reg_rdata,
  output logic transmit_clock_pin_out,
  output logic transmit_clock_pin_oe,
  output logic configurable_logic_cell_tx,
  output logic transmit_irq_req,
  output uatx_cfg_t shared_cfg
);

  uatx_state_t q;
  uatx_state_t n;
  logic active;
  logic tick;
  logic [15:0] div;

  // Transmitter runs only in the enabled asynchronous configuration
  assign active = q.transmit_enable && !q.sync && q.serial_port_enable;

  // Baud divider: 16-bit pair or low byte only
  assign div = q.cfg.brg16 ? q.cfg.brg : {8'h00, q.cfg.brg[7:0]};
  assign tick = (q.cnt == div);

  // Next-state logic
  always_comb begin
    logic [7:0] rd;
    logic act_n;
    logic load;
    rd = UATX_BYTE_RST;
    act_n = 1'b0;
    load = 1'b0;
    n = q;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        UATX_OFS_TXCTL: begin
          n.ninth = reg_wdata[UATX_TXC_NINTH];
          n.cfg.nine = reg_wdata[UATX_TXC_NINE];
          n.sync = reg_wdata[UATX_TXC_SYNC];
          n.transmit_enable = reg_wdata[UATX_TXC_TRANSMIT_ENABLE];
        end
        UATX_OFS_PORT: begin
          n.serial_port_enable = reg_wdata[UATX_PORT_SERIAL_PORT_ENABLE];
        end
        UATX_OFS_BAUD: begin
          n.cfg.brg16 = reg_wdata[UATX_BAUD_BRG16];
          n.pol = reg_wdata[UATX_BAUD_POL];
        end
        UATX_OFS_BRGL: begin
          n.cfg.brg[7:0] = reg_wdata;
        end
        UATX_OFS_BRGH: begin
          n.cfg.brg[15:8] = reg_wdata;
        end
        UATX_OFS_HOLD: begin
          // Ninth bit captured beside the low byte, hardware adds no parity
          if (active) begin
            n.hold = {q.ninth, reg_wdata};
            n.full = 1'b1;
          end
        end
        UATX_OFS_IEN: begin
          n.irq_en = reg_wdata[UATX_FLAG_TXBE];
        end
        default: begin
          // Flag register is read-only; writes leave it alone
          n.irq_en = q.irq_en;
        end
      endcase
    end

    // Frame sequencing on baud ticks
    n.cnt = tick ? 16'h0000 : q.cnt + 16'h0001;
    case (q.st)
      UATX_IDLE: begin
        n.cnt = 16'h0000;
        load = n.full;
      end
      UATX_START: begin
        if (tick) begin
          n.st = UATX_DATA;
        end
      end
      UATX_DATA: begin
        if (tick) begin
          n.shift = {1'b0, q.shift[8:1]};
          n.bits = q.bits + 4'h1;
          if (q.bits == q.last) begin
            n.st = UATX_STOP;
          end
        end
      end
      UATX_STOP: begin
        // Single stop bit, then the queued character or idle
        if (tick) begin
          n.st = UATX_IDLE;
          load = n.full;
        end
      end
      default: begin
        n.st = UATX_IDLE;
      end
    endcase

    // Holding buffer to shift register, frame begins at once
    if (load) begin
      n.shift = n.hold;
      n.last = n.cfg.nine ? UATX_LAST9 : UATX_LAST8;
      n.bits = 4'h0;
      n.full = 1'b0;
      n.cnt = 16'h0000;
      n.st = UATX_START;
    end

    // Leaving the active configuration drops any frame and queue
    if (!active) begin
      n.st = UATX_IDLE;
      n.full = 1'b0;
      n.cnt = 16'h0000;
    end

    // Line level before polarity
    case (n.st)
      UATX_START: n.line = 1'b0;
      UATX_DATA: n.line = n.shift[0];
      default: n.line = 1'b1;
    endcase
    n.pin = n.line ^ n.pol;
    n.oe = n.serial_port_enable;

    // Buffer-empty flag follows the buffer, enable gates request only
    act_n = n.transmit_enable && !n.sync && n.serial_port_enable;
    n.flag = act_n && !n.full;
    n.irq = n.flag && n.irq_en;

    // Read data for the next cycle
    case (reg_addr)
      UATX_OFS_TXCTL: begin
        rd[UATX_TXC_NINTH] = q.ninth;
        rd[UATX_TXC_EMPTY] = (q.st == UATX_IDLE);
        rd[UATX_TXC_NINE] = q.cfg.nine;
        rd[UATX_TXC_SYNC] = q.sync;
        rd[UATX_TXC_TRANSMIT_ENABLE] = q.transmit_enable;
      end
      UATX_OFS_PORT: rd[UATX_PORT_SERIAL_PORT_ENABLE] = q.serial_port_enable;
      UATX_OFS_BAUD: begin
        rd[UATX_BAUD_BRG16] = q.cfg.brg16;
        rd[UATX_BAUD_POL] = q.pol;
      end
      UATX_OFS_BRGL: rd = q.cfg.brg[7:0];
      UATX_OFS_BRGH: rd = q.cfg.brg[15:8];
      UATX_OFS_FLAG: rd[UATX_FLAG_TXBE] = q.flag;
      UATX_OFS_IEN: rd[UATX_FLAG_TXBE] = q.irq_en;
      default: rd = UATX_BYTE_RST;
    endcase
    n.rdata = reg_rd ? rd : UATX_BYTE_RST;
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q.st <= UATX_IDLE;
      q.transmit_enable <= 1'b0;
      q.sync <= 1'b0;
      q.serial_port_enable <= 1'b0;
      q.pol <= 1'b0;
      q.ninth <= 1'b0;
      q.cfg.nine <= 1'b0;
      q.cfg.brg16 <= 1'b0;
      q.cfg.brg <= UATX_BRG_RST;
      q.hold <= UATX_WORD_RST;
      q.full <= 1'b0;
      q.shift <= UATX_WORD_RST;
      q.bits <= 4'h0;
      q.last <= UATX_LAST8;
      q.cnt <= 16'h0000;
      q.line <= 1'b1;
      q.pin <= 1'b1;
      q.oe <= 1'b0;
      q.flag <= 1'b0;
      q.irq_en <= 1'b0;
      q.irq <= 1'b0;
      q.rdata <= UATX_BYTE_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = q.rdata;
  assign transmit_clock_pin_out = q.pin;
  assign transmit_clock_pin_oe = q.oe;
  assign configurable_logic_cell_tx = q.pin;
  assign transmit_irq_req = q.irq;
  assign shared_cfg = q.cfg;

  // Start bit drives space
  property p_start_space;
    @(posedge mclk) disable iff (!arst_n)
      (q.st == UATX_START) |-> (q.line == 1'b0);
  endproperty
  a_start_space: assert property (p_start_space) else $error("start bit not space");

  // Idle line at mark, pin follows polarity
  property p_idle_mark;
    @(posedge mclk) disable iff (!arst_n)
      (q.st == UATX_IDLE) |-> (q.line && (q.pin == !q.pol));
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("idle line not mark");

  // Data bit on line is the shift register bottom
  property p_lsb_first;
    @(posedge mclk) disable iff (!arst_n)
      (q.st == UATX_DATA) |-> (q.line == q.shift[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("data bit order wrong");

  // Phase only moves on a baud tick while active
  property p_bit_length;
    @(posedge mclk) disable iff (!arst_n)
      (q.st != UATX_IDLE && !tick && active)
        |=> ((q.st == $past(q.st)) || (q.st == UATX_IDLE && !active));
  endproperty
  a_bit_length: assert property (p_bit_length) else $error("bit ended early");

  // Inactive configuration forces idle
  property p_inactive_idle;
    @(posedge mclk) disable iff (!arst_n)
      !active |=> (q.st == UATX_IDLE && !q.full);
  endproperty
  a_inactive_idle: assert property (p_inactive_idle) else $error("sent while inactive");

  // Pin driver follows port enable
  property p_pin_dir;
    @(posedge mclk) disable iff (!arst_n)
      (reg_wr && reg_addr == UATX_OFS_PORT)
        |=> (transmit_clock_pin_oe == $past(reg_wdata[UATX_PORT_SERIAL_PORT_ENABLE]));
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction wrong");

  // Write into idle shifter starts a frame next cycle
  property p_load_idle;
    @(posedge mclk) disable iff (!arst_n)
      (reg_wr && reg_addr == UATX_OFS_HOLD && active && q.st == UATX_IDLE)
        |=> (q.st == UATX_START && !q.full && q.flag == active);
  endproperty
  a_load_idle: assert property (p_load_idle) else $error("idle load missed");

  // Queued character follows the stop bit
  property p_load_after_stop;
    @(posedge mclk) disable iff (!arst_n)
      (q.st == UATX_STOP && tick && q.full && active) |=> (q.st == UATX_START);
  endproperty
  a_load_after_stop: assert property (p_load_after_stop) else $error("queued char lost");

  // Flag tracks enable and buffer state
  property p_flag;
    @(posedge mclk) disable iff (!arst_n)
      q.flag == (active && !q.full);
  endproperty
  a_flag: assert property (p_flag) else $error("buffer flag wrong");

  // Character queued while the shifter sends data bits clears the flag next cycle
  property p_flag_busy;
    @(posedge mclk) disable iff (!arst_n)
      (reg_wr && reg_addr == UATX_OFS_HOLD && active && q.st == UATX_DATA) |=> !q.flag;
  endproperty
  a_flag_busy: assert property (p_flag_busy) else $error("flag not cleared");

  // Shift-empty status clears throughout a frame
  property p_shift_empty;
    @(posedge mclk) disable iff (!arst_n)
      (reg_rd && reg_addr == UATX_OFS_TXCTL)
        |=> (reg_rdata[UATX_TXC_EMPTY] == ($past(q.st) == UATX_IDLE));
  endproperty
  a_shift_empty: assert property (p_shift_empty) else $error("shift empty wrong");

  // Nine-bit mode loads a nine-bit length
  property p_nine;
    @(posedge mclk) disable iff (!arst_n)
      ($rose(q.st == UATX_START) && q.cfg.nine) |-> (q.last == UATX_LAST9);
  endproperty
  a_nine: assert property (p_nine) else $error("nine bit length wrong");

  // Request is flag gated by enable
  property p_irq;
    @(posedge mclk) disable iff (!arst_n)
      transmit_irq_req == (q.flag && q.irq_en);
  endproperty
  a_irq: assert property (p_irq) else $error("request gating wrong");

endmodule

`default_nettype wire

// ===== test/uatx_rx_model.sv
// Behavioural model of the remote serial receiver on the line
`timescale 1ns/100ps
`default_nettype none
module uatx_rx_model (
  input wire logic mclk,
  input wire logic line,
  input wire logic pol,
  input wire logic nine,
  input wire logic [7:0] per,
  output logic [8:0] word,
  output logic ferr,
  output logic got
);
  logic lv;
  int i;
  // Undo the chosen polarity so that mark reads as one
  assign lv = line ^ pol;
  // Hunt a start bit, confirm it at mid-bit, then sample once per baud period
  initial begin
    word = 9'h000;
    ferr = 1'b0;
    got = 1'b0;
    forever begin
      @(posedge mclk);
      if (lv === 1'b0) begin
        repeat (per / 2) @(posedge mclk);
        // A short glitch is dropped like a real receiver would
        if (lv === 1'b0) begin
          word = 9'h000;
          for (i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (per) @(posedge mclk);
            word[i] = lv;
          end
          repeat (per) @(posedge mclk);
          ferr = (lv !== 1'b1);
          got = 1'b1;
          @(posedge mclk);
          got = 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/uatx_top_test.sv
// Self-checking bench of the asynchronous serial transmitter
`timescale 1ns/100ps
`default_nettype none
module uatx_top_test;
  import uatx_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [UATX_AW-1:0] reg_addr = '0;
  logic [UATX_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [UATX_DW-1:0] reg_rdata;
  logic pin_out, pin_oe, clc_tx, irq, ferr, got;
  uatx_cfg_t cfg;
  logic [8:0] word;
  logic rd_seen = 1'b0;
  logic pol_v = 1'b0;
  logic nine_v = 1'b0;
  logic mute = 1'b0;
  logic [7:0] rq[$];
  logic [8:0] cq[$];
  logic [31:0] seed = 32'h78f6_77b7;
  logic [7:0] b;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  uatx_top uatx_top_inst (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .transmit_clock_pin_out(pin_out), .transmit_clock_pin_oe(pin_oe),
    .configurable_logic_cell_tx(clc_tx), .transmit_irq_req(irq), .shared_cfg(cfg));
  uatx_rx_model uatx_rx_model_inst (.mclk(mclk), .line(pin_out), .pol(pol_v),
    .nine(nine_v), .per(8'h04), .word(word), .ferr(ferr), .got(got));

  // Clock of 40 ns
  always #20 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One-cycle write strobe, then one idle cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  // One-cycle read strobe; the expected answer is queued for the watcher
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    rq.push_back(e);
    @(posedge mclk);
  endtask

  // Read data are compared in the one cycle after the strobe; cycle ceiling
  always @(posedge mclk) begin
    if (rd_seen) begin
      check("reg_rdata", {8'h00, rq.pop_front()}, {8'h00, reg_rdata});
    end
    rd_seen <= reg_rd;
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  // Each decoded character is compared with the oldest expected one, except while mute is set
  always @(posedge got) begin
    if (!mute) begin
      check("frame", {7'h00, cq.size() > 0 ? cq.pop_front() : ~word}, {6'h00, ferr, word});
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    check("idle pin", 16'h0001, {15'h0000, pin_out});
    @(posedge mclk);
    rd(UATX_OFS_TXCTL, 8'h02);
    rd(UATX_OFS_FLAG, 8'h00);
    wr(UATX_OFS_BRGL, 8'h03);
    wr(UATX_OFS_BRGH, 8'h01);
    wr(UATX_OFS_HOLD, 8'h55);
    wr(UATX_OFS_PORT, 8'h80);
    @(negedge mclk);
    check("pin oe", 16'h0001, {15'h0000, pin_oe});
    check("cfg brg", 16'h0103, cfg.brg);
    @(posedge mclk);
    wr(UATX_OFS_TXCTL, 8'h20);
    rd(UATX_OFS_FLAG, 8'h01);
    wr(UATX_OFS_FLAG, 8'h00);
    rd(UATX_OFS_FLAG, 8'h01);
    // Every polarity and character length, two characters back to back
    for (int m = 0; m < 4; m++) begin
      pol_v <= m[0];
      nine_v <= m[1];
      wr(UATX_OFS_BAUD, {3'h0, m[0], 4'h0});
      @(negedge mclk);
      check("idle level", {15'h0000, ~m[0]}, {15'h0000, pin_out});
      check("cell copy", {15'h0000, pin_out}, {15'h0000, clc_tx});
      @(posedge mclk);
      seed = lfsr(seed);
      b = seed[7:0];
      wr(UATX_OFS_TXCTL, {2'h0, 1'b1, 2'h0, m[1], 1'b0, ^b});
      wr(UATX_OFS_HOLD, b);
      cq.push_back({m[1] & ^b, b});
      wr(UATX_OFS_IEN, 8'h01);
      @(negedge mclk);
      check("irq set", 16'h0001, {15'h0000, irq});
      @(posedge mclk);
      b = ~b;
      wr(UATX_OFS_HOLD, b);
      cq.push_back({m[1] & ^b, b});
      rd(UATX_OFS_FLAG, 8'h00);
      check("irq clear", 16'h0000, {15'h0000, irq});
      rd(UATX_OFS_TXCTL, {2'h0, 1'b1, 2'h0, m[1], 1'b0, ^b});
      wr(UATX_OFS_IEN, 8'h00);
      for (int k = 0; k < 300 && cq.size() > 0; k++) begin
        @(posedge mclk);
      end
      repeat (4) @(posedge mclk);
      rd(UATX_OFS_FLAG, 8'h01);
      rd(UATX_OFS_TXCTL, {2'h0, 1'b1, 2'h0, m[1], 1'b1, ^b});
    end
    // Synchronous select blocks transmission and holding-buffer writes
    wr(UATX_OFS_TXCTL, 8'h30);
    wr(UATX_OFS_HOLD, 8'h3c);
    rd(UATX_OFS_TXCTL, 8'h32);
    rd(UATX_OFS_FLAG, 8'h00);
    wr(UATX_OFS_TXCTL, 8'h20);
    // Sixteen-bit divider stretches the start bit, then the port enable drops mid-frame
    mute <= 1'b1;
    wr(UATX_OFS_BAUD, 8'h18);
    wr(UATX_OFS_HOLD, 8'h0f);
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    check("long start", 16'h0001, {15'h0000, pin_out});
    @(posedge mclk);
    wr(UATX_OFS_PORT, 8'h00);
    @(negedge mclk);
    check("oe off", 16'h0000, {15'h0000, pin_oe});
    check("abort idle", 16'h0000, {15'h0000, pin_out});
    @(posedge mclk);
    rd(UATX_OFS_FLAG, 8'h00);
    repeat (60) @(posedge mclk);
    check("drained", 16'h0000, 16'(cq.size()));
    stop_test();
  end
endmodule
`default_nettype wire
